//--- common/ccs_pkg.sv
// Package for the control-register space and data-register operations
package ccs_pkg;

    // Control-register codes
    localparam logic [11:0] CCS_CODE_CACHE_CTRL  = 12'h002;
    localparam logic [11:0] CCS_CODE_ACCESS_A0   = 12'h004;
    localparam logic [11:0] CCS_CODE_ACCESS_A1   = 12'h005;
    localparam logic [11:0] CCS_CODE_DATA_BASE   = 12'h080;
    localparam logic [11:0] CCS_CODE_ADDR_BASE   = 12'h088;
    localparam logic [11:0] CCS_CODE_ALT_SP      = 12'h800;
    localparam logic [11:0] CCS_CODE_VECTOR_BASE = 12'h801;
    localparam logic [11:0] CCS_CODE_MAC_STATUS  = 12'h804;
    localparam logic [11:0] CCS_CODE_MAC_MASK    = 12'h805;
    localparam logic [11:0] CCS_CODE_MAC_SUM0    = 12'h806;
    localparam logic [11:0] CCS_CODE_MAC_EXT01   = 12'h807;
    localparam logic [11:0] CCS_CODE_MAC_EXT23   = 12'h808;
    localparam logic [11:0] CCS_CODE_MAC_SUM1    = 12'h809;
    localparam logic [11:0] CCS_CODE_MAC_SUM2    = 12'h80A;
    localparam logic [11:0] CCS_CODE_MAC_SUM3    = 12'h80B;
    localparam logic [11:0] CCS_CODE_STATUS      = 12'h80E;
    localparam logic [11:0] CCS_CODE_PC          = 12'h80F;
    localparam logic [11:0] CCS_CODE_FLASH_BASE  = 12'hC04;
    localparam logic [11:0] CCS_CODE_SRAM_BASE   = 12'hC05;

    // Field positions and masks
    localparam int          CCS_LS_BIT        = 8;   // load/store digit
    localparam int          CCS_SUPV_BIT      = 13;  // status supervisor bit
    localparam logic [31:0] CCS_VBR_MASK      = 32'hFFF0_0000;
    localparam logic [15:0] CCS_STATUS_MASK   = 16'hB71F;
    localparam logic [31:0] CCS_RESET_WORD    = 32'h0000_0000;
    localparam logic [15:0] CCS_RESET_STATUS  = 16'h2700;
    localparam logic [31:0] CCS_STACK_STEP    = 32'h0000_0004;
    localparam logic [5:0]  CCS_FF1_NONE      = 6'h20;

    // Data-register operations
    typedef enum logic [2:0] {
        CCS_OP_NONE  = 3'b000,
        CCS_OP_BIT_REVERSE = 3'b001,
        CCS_OP_BYTESW = 3'b010,
        CCS_OP_FF1    = 3'b011,
        CCS_OP_PUSHLD = 3'b100
    } ccs_op_t;

    // Control-space access request
    typedef struct packed {
        logic        valid;
        logic        write;    // move_control write
        logic        debug;    // debug path: all registers writable
        logic [11:0] code;
        logic [31:0] wdata;
    } ccs_req_t;

    // Operation request
    typedef struct packed {
        logic        valid;
        ccs_op_t     op;
        logic [2:0]  dreg;
        logic [15:0] imm;
    } ccs_opreq_t;

    // Stack push toward memory
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [15:0] data;
    } ccs_push_t;

    // Push-then-load sequencer states
    typedef enum logic [1:0] {
        CCS_ST_IDLE = 2'b00,
        CCS_ST_PUSH = 2'b01,
        CCS_ST_LOAD = 2'b10
    } ccs_state_t;

endpackage

//--- verilog/ccs_bitops.sv
// Combinational bit-reverse, byte-swap and find-first-one unit
module ccs_bitops (
    // Operand
    input  wire logic [31:0]    operand,
    input  wire ccs_pkg::ccs_op_t op,
    // Result
    output logic [31:0]         result
);
    import ccs_pkg::*;

    logic [31:0] rev_w;
    logic [5:0]  ff1_w;

    // Mirror and leading-one count
    always_comb begin
        ff1_w = CCS_FF1_NONE;
        for (int i = 0; i < 32; i++) begin
            rev_w[i] = operand[31 - i];
        end
        for (int i = 0; i < 32; i++) begin
            // Last hit from bit 0 upward leaves the highest set bit
            if (operand[i]) begin
                ff1_w = 6'(31 - i);
            end
        end
    end

    // Select the result by operation
    always_comb begin
        case (op)
            CCS_OP_BIT_REVERSE: result = rev_w;
            CCS_OP_BYTESW: result = {operand[7:0], operand[15:8],
                                     operand[23:16], operand[31:24]};
            CCS_OP_FF1:    result = {26'h0, ff1_w};
            default:       result = operand;
        endcase
    end
endmodule

//--- verilog/ccs_ctrl_space.sv
// Control-register space with data-register operations
module ccs_ctrl_space (
    // Clock and reset
    input  wire logic               sys_clk,
    input  wire logic               reset,
    // Control-space access
    input  wire ccs_pkg::ccs_req_t  req,
    output logic [31:0]             rdata,
    output logic                    ack,
    output logic                    refused,
    // Data-register operations
    input  wire ccs_pkg::ccs_opreq_t opreq,
    output logic                    op_busy,
    output logic                    op_done,
    output ccs_pkg::ccs_push_t      push,
    // Register views for the core
    output logic [15:0]             status_word,
    output logic [31:0]             vector_base,
    output logic [31:0]             cache_control
);
    import ccs_pkg::*;

    // Register storage
    logic [31:0] data_regs_bank_q [8];
    logic [31:0] address_regs_bank_q [7];
    logic [31:0] sp_active_q;
    logic [31:0] alt_stack_ptr_q;
    logic [31:0] cache_control_q;
    logic [31:0] access_attr_q [2];
    logic [31:0] vector_base_q;
    logic [31:0] mac_status_q;
    logic [31:0] mac_addr_mask_q;
    logic [31:0] mac_sums_q [4];
    logic [31:0] mac_sum_ext_01_q;
    logic [31:0] mac_sum_ext_23_q;
    logic [15:0] status_word_q;
    logic [31:0] program_counter_q;
    logic [31:0] flash_base_q;
    logic [31:0] sram_base_q;
    logic [31:0] rdata_q;
    logic        ack_q;
    logic        refused_q;

    // Op sequencer
    ccs_state_t  state_q;
    ccs_state_t  state_d;
    logic [15:0] imm_q;
    ccs_push_t   push_q;
    logic        op_done_q;
    logic [31:0] op_result_w;
    logic        op_hit_w;

    // Decode
    logic [11:0] code_w;
    logic        is_gpr_w;
    logic        is_store_w;
    logic [3:0]  gpr_idx_w;
    logic        known_w;
    logic        writable_w;
    logic        wr_en_w;
    logic [31:0] rd_w;

    assign code_w     = req.code;
    // General registers: hundreds digit 0 or 1, then 8x
    assign is_gpr_w   = (code_w[11:9] == 3'h0) && (code_w[7:4] == 4'h8);
    assign is_store_w = code_w[CCS_LS_BIT];
    assign gpr_idx_w  = code_w[3:0];

    // Read mux and write permission, address-style decode chain
    always_comb begin
        rd_w       = CCS_RESET_WORD;
        known_w    = 1'b1;
        writable_w = 1'b0;
        if (is_gpr_w) begin
            if (!gpr_idx_w[3]) begin
                rd_w = data_regs_bank_q[gpr_idx_w[2:0]];
            end else if (gpr_idx_w[2:0] == 3'h7) begin
                rd_w = sp_active_q;
            end else begin
                rd_w = address_regs_bank_q[gpr_idx_w[2:0]];
            end
        end else if (code_w == CCS_CODE_CACHE_CTRL) begin
            rd_w = cache_control_q;
            writable_w = 1'b1;
        end else if (code_w == CCS_CODE_ACCESS_A0) begin
            rd_w = access_attr_q[0];
            writable_w = 1'b1;
        end else if (code_w == CCS_CODE_ACCESS_A1) begin
            rd_w = access_attr_q[1];
            writable_w = 1'b1;
        end else if (code_w == CCS_CODE_ALT_SP) begin
            rd_w = alt_stack_ptr_q;
        end else if (code_w == CCS_CODE_VECTOR_BASE) begin
            rd_w = vector_base_q & CCS_VBR_MASK;
            writable_w = 1'b1;
        end else if (code_w == CCS_CODE_MAC_STATUS) begin
            rd_w = mac_status_q;
        end else if (code_w == CCS_CODE_MAC_MASK) begin
            rd_w = mac_addr_mask_q;
        end else if (code_w == CCS_CODE_MAC_SUM0) begin
            rd_w = mac_sums_q[0];
        end else if (code_w == CCS_CODE_MAC_EXT01) begin
            rd_w = mac_sum_ext_01_q;
        end else if (code_w == CCS_CODE_MAC_EXT23) begin
            rd_w = mac_sum_ext_23_q;
        end else if (code_w == CCS_CODE_MAC_SUM1) begin
            rd_w = mac_sums_q[1];
        end else if (code_w == CCS_CODE_MAC_SUM2) begin
            rd_w = mac_sums_q[2];
        end else if (code_w == CCS_CODE_MAC_SUM3) begin
            rd_w = mac_sums_q[3];
        end else if (code_w == CCS_CODE_STATUS) begin
            rd_w = {16'h0, status_word_q};
        end else if (code_w == CCS_CODE_PC) begin
            rd_w = program_counter_q;
            writable_w = 1'b1;
        end else if (code_w == CCS_CODE_FLASH_BASE) begin
            rd_w = flash_base_q;
            writable_w = 1'b1;
        end else if (code_w == CCS_CODE_SRAM_BASE) begin
            rd_w = sram_base_q;
            writable_w = 1'b1;
        end else begin
            // Unknown code: reads zero, any write is refused
            known_w = 1'b0;
        end
    end

    // Debug path may write any register; move_control only the allowed set.
    // A store-digit code only reads a general register out, never loads it.
    assign wr_en_w = req.valid && req.write && known_w &&
                     !(is_gpr_w && is_store_w) &&
                     (req.debug || (writable_w && !is_gpr_w));

    // Read data and answer, one cycle after the request
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rdata_q   <= CCS_RESET_WORD;
            ack_q     <= 1'b0;
            refused_q <= 1'b0;
        end else begin
            ack_q     <= req.valid;
            refused_q <= req.valid && req.write && !wr_en_w;
            if (req.valid && !req.write) begin
                rdata_q <= rd_w;
            end
        end
    end

    // Memory management, local memory and misc registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cache_control_q   <= CCS_RESET_WORD;
            access_attr_q[0]  <= CCS_RESET_WORD;
            access_attr_q[1]  <= CCS_RESET_WORD;
            vector_base_q     <= CCS_RESET_WORD;
            program_counter_q <= CCS_RESET_WORD;
            flash_base_q      <= CCS_RESET_WORD;
            sram_base_q       <= CCS_RESET_WORD;
            mac_status_q      <= CCS_RESET_WORD;
            mac_addr_mask_q   <= CCS_RESET_WORD;
            mac_sum_ext_01_q  <= CCS_RESET_WORD;
            mac_sum_ext_23_q  <= CCS_RESET_WORD;
            for (int i = 0; i < 4; i++) begin
                mac_sums_q[i] <= CCS_RESET_WORD;
            end
        end else if (wr_en_w) begin
            if (code_w == CCS_CODE_CACHE_CTRL) begin
                cache_control_q <= req.wdata;
            end else if (code_w == CCS_CODE_ACCESS_A0) begin
                access_attr_q[0] <= req.wdata;
            end else if (code_w == CCS_CODE_ACCESS_A1) begin
                access_attr_q[1] <= req.wdata;
            end else if (code_w == CCS_CODE_VECTOR_BASE) begin
                vector_base_q <= req.wdata & CCS_VBR_MASK;
            end else if (code_w == CCS_CODE_PC) begin
                program_counter_q <= req.wdata;
            end else if (code_w == CCS_CODE_FLASH_BASE) begin
                flash_base_q <= req.wdata;
            end else if (code_w == CCS_CODE_SRAM_BASE) begin
                sram_base_q <= req.wdata;
            end else if (code_w == CCS_CODE_MAC_STATUS) begin
                mac_status_q <= req.wdata;
            end else if (code_w == CCS_CODE_MAC_MASK) begin
                mac_addr_mask_q <= req.wdata;
            end else if (code_w == CCS_CODE_MAC_SUM0) begin
                mac_sums_q[0] <= req.wdata;
            end else if (code_w == CCS_CODE_MAC_EXT01) begin
                mac_sum_ext_01_q <= req.wdata;
            end else if (code_w == CCS_CODE_MAC_EXT23) begin
                mac_sum_ext_23_q <= req.wdata;
            end else if (code_w == CCS_CODE_MAC_SUM1) begin
                mac_sums_q[1] <= req.wdata;
            end else if (code_w == CCS_CODE_MAC_SUM2) begin
                mac_sums_q[2] <= req.wdata;
            end else if (code_w == CCS_CODE_MAC_SUM3) begin
                mac_sums_q[3] <= req.wdata;
            end
        end
    end

    // Shared operation unit works on the selected data register
    ccs_bitops u_bitops (
        .operand (data_regs_bank_q[opreq.dreg]),
        .op      (opreq.op),
        .result  (op_result_w)
    );

    // A bit operation is taken only while the sequencer is idle
    assign op_hit_w = opreq.valid && (state_q == CCS_ST_IDLE) &&
                      (opreq.op == CCS_OP_BIT_REVERSE ||
                       opreq.op == CCS_OP_BYTESW ||
                       opreq.op == CCS_OP_FF1);

    // Data registers: debug writes, then results of the bit operations.
    // Both apply, so a write to another register is never lost; the later
    // assignment lets the operation win on the same register.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 8; i++) begin
                data_regs_bank_q[i] <= CCS_RESET_WORD;
            end
        end else begin
            if (wr_en_w && is_gpr_w && !gpr_idx_w[3]) begin
                data_regs_bank_q[gpr_idx_w[2:0]] <= req.wdata;
            end
            if (op_hit_w) begin
                data_regs_bank_q[opreq.dreg] <= op_result_w;
            end
        end
    end

    // Address registers 0-6 via the debug path
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 7; i++) begin
                address_regs_bank_q[i] <= CCS_RESET_WORD;
            end
        end else if (wr_en_w && is_gpr_w && gpr_idx_w[3] &&
                     gpr_idx_w[2:0] != 3'h7) begin
            address_regs_bank_q[gpr_idx_w[2:0]] <= req.wdata;
        end
    end

    // Two physical stack pointers; swap when the supervisor bit changes.
    // The sequencer owns them during push-and-load, so a debug write to a
    // stack pointer in those two cycles may be dropped.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            sp_active_q     <= CCS_RESET_WORD;
            alt_stack_ptr_q <= CCS_RESET_WORD;
        end else if (state_q == CCS_ST_PUSH) begin
            sp_active_q <= sp_active_q - CCS_STACK_STEP;
        end else if (state_q == CCS_ST_LOAD &&
                     imm_q[CCS_SUPV_BIT] != status_word_q[CCS_SUPV_BIT]) begin
            sp_active_q     <= alt_stack_ptr_q;
            alt_stack_ptr_q <= sp_active_q;
        end else if (wr_en_w && code_w == CCS_CODE_STATUS &&
                     req.wdata[CCS_SUPV_BIT] !=
                     status_word_q[CCS_SUPV_BIT]) begin
            sp_active_q     <= alt_stack_ptr_q;
            alt_stack_ptr_q <= sp_active_q;
        end else if (wr_en_w && is_gpr_w && gpr_idx_w == 4'hF) begin
            sp_active_q <= req.wdata;
        end else if (wr_en_w && code_w == CCS_CODE_ALT_SP) begin
            alt_stack_ptr_q <= req.wdata;
        end
    end

    // Status word: debug write, or the load step of push-and-load
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            status_word_q <= CCS_RESET_STATUS;
        end else if (state_q == CCS_ST_LOAD) begin
            status_word_q <= imm_q & CCS_STATUS_MASK;
        end else if (wr_en_w && code_w == CCS_CODE_STATUS) begin
            status_word_q <= req.wdata[15:0] & CCS_STATUS_MASK;
        end
    end

    // Push-and-load sequencer: push strictly before load
    always_comb begin
        state_d = state_q;
        case (state_q)
            CCS_ST_IDLE: begin
                if (opreq.valid && opreq.op == CCS_OP_PUSHLD) begin
                    state_d = CCS_ST_PUSH;
                end
            end
            CCS_ST_PUSH: state_d = CCS_ST_LOAD;
            CCS_ST_LOAD: state_d = CCS_ST_IDLE;
            default:     state_d = CCS_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_q   <= CCS_ST_IDLE;
            imm_q     <= 16'h0000;
            push_q    <= '0;
            op_done_q <= 1'b0;
        end else begin
            state_q   <= state_d;
            op_done_q <= (state_q == CCS_ST_LOAD) ||
                         (state_q == CCS_ST_IDLE && opreq.valid &&
                          opreq.op != CCS_OP_PUSHLD &&
                          opreq.op != CCS_OP_NONE);
            if (state_q == CCS_ST_IDLE && opreq.valid) begin
                imm_q <= opreq.imm;
            end
            // Word pushed holds the status before the load
            push_q.valid <= (state_q == CCS_ST_PUSH);
            if (state_q == CCS_ST_PUSH) begin
                push_q.addr <= sp_active_q - CCS_STACK_STEP;
                push_q.data <= status_word_q;
            end
        end
    end

    // Outputs
    assign rdata         = rdata_q;
    assign ack           = ack_q;
    assign refused       = refused_q;
    assign op_busy       = (state_q != CCS_ST_IDLE);
    assign op_done       = op_done_q;
    assign push          = push_q;
    assign status_word   = status_word_q;
    assign vector_base   = vector_base_q;
    assign cache_control = cache_control_q;
endmodule

//--- tb/ccs_ctrl_space_asserts.sv
// Port-level checks for the control-space block
module ccs_ctrl_space_asserts (
    // Clock and reset
    input wire logic                sys_clk,
    input wire logic                reset,
    // Control-space access
    input wire ccs_pkg::ccs_req_t   req,
    input wire logic [31:0]         rdata,
    input wire logic                ack,
    input wire logic                refused,
    // Operations
    input wire ccs_pkg::ccs_opreq_t opreq,
    input wire logic                op_busy,
    input wire logic                op_done,
    input wire ccs_pkg::ccs_push_t  push,
    // Register views
    input wire logic [15:0]         status_word,
    input wire logic [31:0]         vector_base,
    input wire logic [31:0]         cache_control
);
    timeunit 1ns;
    timeprecision 100ps;
    import ccs_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    logic wr_nd;
    logic go_pl;
    // Plain-instruction writes and accepted push-and-load starts
    assign wr_nd = req.valid && req.write && !req.debug;
    assign go_pl = opreq.valid && opreq.op == CCS_OP_PUSHLD && !op_busy;
    property p_ack; ack == $past(req.valid); endproperty
    a_ack: assert property (p_ack) else $error("ack not one cycle after request");
    property p_ro; wr_nd && req.code inside {12'h800, 12'h804, 12'h80E} |=> refused; endproperty
    a_ro: assert property (p_ro) else $error("read-only write not refused");
    property p_rw; wr_nd && req.code inside {12'h002, 12'h004, 12'h005, 12'h801,
        12'h80F, 12'hC04, 12'hC05} |=> !refused; endproperty
    a_rw: assert property (p_rw) else $error("writable register refused");
    property p_cache; req.valid && req.write && req.code == 12'h002
        |=> cache_control == $past(req.wdata); endproperty
    a_cache: assert property (p_cache) else $error("cache control not stored");
    property p_vbr; vector_base[19:0] == 20'h00000; endproperty
    a_vbr: assert property (p_vbr) else $error("vector base low bits set");
    property p_vrd; req.valid && !req.write && req.code == 12'h801
        |=> rdata == vector_base; endproperty
    a_vrd: assert property (p_vrd) else $error("vector base read wrong");
    property p_pl; go_pl |=> op_busy ##1 (push.valid && push.data ==
        $past(status_word, 2)) ##1 (op_done && !op_busy); endproperty
    a_pl: assert property (p_pl) else $error("push-and-load order wrong");
    property p_ld; go_pl |-> ##3 status_word == ($past(opreq.imm, 3) & CCS_STATUS_MASK);
    endproperty
    a_ld: assert property (p_ld) else $error("status not loaded from immediate");
    property p_ref; refused |-> ack; endproperty
    a_ref: assert property (p_ref) else $error("refused without ack");
    property p_st; req.valid && req.write && req.code[11:8] == 4'h1 &&
        req.code[7:4] == 4'h8 |=> refused; endproperty
    a_st: assert property (p_st) else $error("store-digit write taken");
    // Main scenarios reached
    c_push: cover property (push.valid);
    c_ref: cover property (refused);
    c_done: cover property (op_done);
endmodule

//--- tb/ccs_stack_sink.sv
// Stack memory stand-in that records each status push
module ccs_stack_sink (
    // Clock and reset
    input wire logic               sys_clk,
    input wire logic               reset,
    // Push from the block
    input wire ccs_pkg::ccs_push_t push,
    // Capture for the bench
    output logic [31:0]            last_addr,
    output logic [15:0]            last_data,
    output logic [7:0]             n_push
);
    timeunit 1ns;
    timeprecision 100ps;
    import ccs_pkg::*;
    // Memory never stalls, so every pushed word is taken at once
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            last_addr <= 32'h0;
            last_data <= 16'h0;
            n_push    <= 8'h0;
        end else if (push.valid) begin
            last_addr <= push.addr;
            last_data <= push.data;
            n_push    <= n_push + 8'h1;
        end
    end
endmodule

//--- tb/testbench.sv
// Self-checking bench for the control-space block
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import ccs_pkg::*;
    logic sys_clk, reset, ack, refused, op_busy, op_done;
    ccs_req_t req;
    ccs_opreq_t opreq;
    ccs_push_t push;
    logic [31:0] rdata, vector_base, cache_control, p_addr;
    logic [15:0] status_word, p_data;
    logic [7:0] n_push;
    int bad_count = 0, n_checks = 0, cycles = 0;
    localparam logic [11:0] CODES [16] = '{12'h002, 12'h004, 12'h005, 12'h801,
        12'h80F, 12'hC04, 12'hC05, 12'h800, 12'h804, 12'h805, 12'h806, 12'h807,
        12'h808, 12'h809, 12'h80A, 12'h80B};
    ccs_ctrl_space ccs_ctrl_space_i (.sys_clk(sys_clk), .reset(reset), .req(req),
        .rdata(rdata), .ack(ack), .refused(refused), .opreq(opreq),
        .op_busy(op_busy), .op_done(op_done), .push(push),
        .status_word(status_word), .vector_base(vector_base),
        .cache_control(cache_control));
    ccs_stack_sink ccs_stack_sink_i (.sys_clk(sys_clk), .reset(reset),
        .push(push), .last_addr(p_addr), .last_data(p_data), .n_push(n_push));
    // Clock at 40 MHz
    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    // Hang guard, well above the roughly 160 cycles the tests need
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string what);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One access; ack must follow exactly one edge later
    task automatic acc(input logic wr, dbg, input logic [11:0] code,
                       input logic [31:0] wd, output logic [31:0] rd_v,
                       output logic rf);
        @(posedge sys_clk);
        #1 req = '{1'b1, wr, dbg, code, wd};
        @(posedge sys_clk);
        #1 req.valid = 1'b0;
        chk({31'h0, ack}, 32'h1, "ack");
        rd_v = rdata;
        rf = refused;
    endtask
    task automatic wr(input logic dbg, input logic [11:0] code,
                      input logic [31:0] v, input logic exp_rf);
        logic [31:0] d;
        logic rf;
        acc(1'b1, dbg, code, v, d, rf);
        chk({31'h0, rf}, {31'h0, exp_rf}, "refused");
    endtask
    task automatic rd(input logic [11:0] code, input logic [31:0] exp,
                      input string what);
        logic [31:0] d;
        logic rf;
        acc(1'b0, 1'b0, code, 32'h0, d, rf);
        chk(d, exp, what);
    endtask
    // Operation; completion awaited under a bound
    task automatic op(input ccs_op_t o, input logic [2:0] d,
                      input logic [15:0] imm);
        int n;
        @(posedge sys_clk);
        #1 opreq = '{1'b1, o, d, imm};
        @(posedge sys_clk);
        #1 opreq.valid = 1'b0;
        n = 0;
        while (op_done !== 1'b1 && n < 8) begin
            @(posedge sys_clk);
            #1 n++;
        end
        chk({31'h0, op_done}, 32'h1, "op_done");
    endtask
    function automatic logic [31:0] pat(int i);
        return {CODES[i], 8'h5A, CODES[i]};
    endfunction
    function automatic logic [31:0] rev(input logic [31:0] v);
        for (int i = 0; i < 32; i++) rev[i] = v[31 - i];
    endfunction
    function automatic logic [31:0] ff1(input logic [31:0] v);
        ff1 = 32'h20;
        for (int i = 0; i < 32; i++) if (v[31 - i] && ff1 == 32'h20) ff1 = i;
    endfunction
    // Writability by plain writes, then decode of each of the 16 codes in CODES
    task automatic t_space();
        chk({16'h0, status_word}, 32'h2700, "status reset");
        for (int i = 0; i < 16; i++) begin
            wr(1'b0, CODES[i], pat(i), i > 6);
            if (i > 6) begin
                rd(CODES[i], 32'h0, "kept");
                wr(1'b1, CODES[i], pat(i), 1'b0);
            end
        end
        for (int i = 0; i < 16; i++)
            rd(CODES[i], (i == 3) ? pat(i) & CCS_VBR_MASK : pat(i), "decode");
        chk(cache_control, pat(0), "cache view");
        chk(vector_base, pat(3) & CCS_VBR_MASK, "vbr view");
        $display("test space done");
    endtask
    // Bit, byte and find-first-one operations on data registers
    task automatic t_ops();
        logic [31:0] x;
        x = 32'h0012_34F1;
        wr(1'b1, 12'h083, x, 1'b0);
        rd(12'h183, x, "data load");
        wr(1'b0, 12'h083, 32'h1, 1'b1);
        wr(1'b1, 12'h183, 32'h1, 1'b1);
        wr(1'b1, 12'h003, 32'h1, 1'b1);
        rd(12'h003, 32'h0, "unknown code");
        op(CCS_OP_BIT_REVERSE, 3'h3, 16'h0);
        x = rev(x);
        rd(12'h183, x, "bit_reverse");
        op(CCS_OP_BYTESW, 3'h3, 16'h0);
        x = {x[7:0], x[15:8], x[23:16], x[31:24]};
        rd(12'h183, x, "byteswap");
        op(CCS_OP_FF1, 3'h3, 16'h0);
        rd(12'h183, ff1(x), "ff1");
        wr(1'b1, 12'h085, 32'h0, 1'b0);
        op(CCS_OP_FF1, 3'h5, 16'h0);
        rd(12'h185, 32'h20, "ff1 zero");
        $display("test ops done");
    endtask
    // Stack pointers and push-then-load of the status
    task automatic t_stack();
        wr(1'b1, 12'h08B, 32'hA3A3_0000, 1'b0);
        rd(12'h18B, 32'hA3A3_0000, "addr reg");
        wr(1'b1, 12'h08F, 32'h0000_1000, 1'b0);
        wr(1'b1, 12'h800, 32'h0000_2000, 1'b0);
        rd(12'h18F, 32'h0000_1000, "active sp");
        wr(1'b0, 12'h80E, 32'h0, 1'b1);
        chk({16'h0, status_word}, 32'h2700, "status kept");
        op(CCS_OP_PUSHLD, 3'h0, 16'h0700);
        chk({24'h0, n_push}, 32'h1, "push count");
        chk({16'h0, p_data}, 32'h2700, "pushed status");
        chk(p_addr, 32'h0000_0FFC, "push addr");
        chk({16'h0, status_word}, 32'h0700, "loaded status");
        rd(12'h18F, 32'h0000_2000, "user sp");
        rd(12'h800, 32'h0000_0FFC, "other sp");
        $display("test stack done");
    endtask
    // Main sequence
    initial begin
        req = '0;
        opreq = '0;
        reset = 1'b1;
        repeat (6) @(posedge sys_clk);
        #1 reset = 1'b0;
        t_space();
        t_ops();
        t_stack();
        close_out();
    end
endmodule
bind ccs_ctrl_space ccs_ctrl_space_asserts ccs_ctrl_space_asserts_i (
    .sys_clk(sys_clk), .reset(reset), .req(req), .rdata(rdata), .ack(ack),
    .refused(refused), .opreq(opreq), .op_busy(op_busy), .op_done(op_done),
    .push(push), .status_word(status_word), .vector_base(vector_base),
    .cache_control(cache_control));
